/* rtl/qdac_pkg.sv */
package qdac_pkg;

  // ==========================================================================
  // Serial word layout, first bit on the wire is the most significant.
  // ==========================================================================
  localparam int unsigned WORD_BITS     = 24;
  localparam int unsigned CNT_BITS      = 5;
  localparam int unsigned PA_BITS       = 5;
  localparam int unsigned CH_BITS       = 2;
  localparam int unsigned CODE_BITS     = 14;
  localparam int unsigned NUM_CH        = 4;
  localparam int unsigned PA_MSB        = 23;
  localparam int unsigned PA_LSB        = 19;
  localparam int unsigned CH_MSB        = 18;
  localparam int unsigned CH_LSB        = 17;
  localparam int unsigned CODE_MSB      = 13;
  localparam int unsigned CODE_LSB      = 0;

  // Last bit index of a frame and the saturated count after a full word.
  localparam logic [CNT_BITS-1:0] CNT_LAST = 5'h17;
  localparam logic [CNT_BITS-1:0] CNT_DONE = 5'h18;
  localparam logic [CNT_BITS-1:0] CNT_ZERO = 5'h00;

  // ==========================================================================
  // Buffering and reset values.
  // ==========================================================================
  localparam int unsigned FIFO_DEPTH    = 4;
  localparam logic [CODE_BITS-1:0] CODE_RESET = 14'h0000;

  // ==========================================================================
  // Carriers.
  // ==========================================================================
  typedef logic [CODE_BITS-1:0] code_t;
  typedef code_t [NUM_CH-1:0]   code_bank_t;

  typedef struct packed {
    logic                 check_bypass;
    logic [PA_BITS-1:0]   pkg_addr;
    logic [CH_BITS-1:0]   chan;
    code_t                code;
  } frame_word_t;

  localparam int unsigned FRAME_W = $bits(frame_word_t);
  localparam frame_word_t FRAME_RESET = '0;

endpackage

/* rtl/quad_dac_serial_load_control.sv */
// What this block does
// RULE1: Serial data is sampled into the shift path on each falling serial clock edge inside a frame.
// RULE2: The package address comes from five strap inputs, and normally only matching frames are taken.
// RULE3: With the address check enable low, each frame's package address is compared to the straps first.
// RULE4: With the address check enable high, the comparison is skipped but the channel is still decoded.
// RULE5: A falling frame sync starts a frame, and data counts only after it.
// RULE6: The load input is a level that decides when the converter latches take the input registers.
// RULE7: With load held high, only the addressed input register changes and all latches hold.
// RULE8: Bringing load low copies all four input registers into their latches at once.
// RULE9: While clear is low every output is forced to the sense-ground level.
// RULE10: Clear acts at once by level, active low, without any serial clock edge.
// RULE11: After a clear the outputs stay at sense ground until load is next brought low.
// RULE12: The controlling logic is expected to hold clear low during power-on.
// RULE13: Word width, bit order and field layout follow the serial word definition in the package.
// RULE14: Clock edges outside a frame are ignored and a frame cut short is dropped.
`timescale 1ns/1ps
`default_nettype none

module quad_dac_serial_load_control (
  // System clock, reset and enable.
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire logic                     ce,
  // Serial link.
  input  wire logic                     sclk,
  input  wire logic                     frame_sync_n,
  input  wire logic                     serial_data,
  input  wire logic                     package_addr_check_enable,
  // Straps and control pins.
  input  wire logic [4:0]               package_addr_strap,
  input  wire logic                     load_converter_n,
  input  wire logic                     clear_outputs_n,
  input  wire logic [13:0]              sense_ground_ref,
  // Converter side.
  output var qdac_pkg::code_bank_t      analog_out,
  output logic                          outputs_grounded,
  // Word status.
  output logic                          word_accepted,
  output logic                          word_rejected,
  output logic                          word_dropped
);

  // ==========================================================================
  // Declarations.
  // ==========================================================================
  qdac_pkg::frame_word_t  link_word;
  logic                   link_toggle;

  logic                   tog_s1_q;
  logic                   tog_s2_q;
  logic                   tog_s3_q;
  logic [4:0]             strap_s1_q;
  logic [4:0]             strap_s2_q;
  logic                   load_s1_q;
  logic                   load_s2_q;
  logic                   load_s3_q;
  logic                   clr_s1_q;
  logic                   clr_s2_q;
  qdac_pkg::code_t        sg_s1_q;
  qdac_pkg::code_t        sg_s2_q;

  logic                   word_event;
  logic                   load_fall;

  logic                   pend_valid_q;
  logic                   pend_valid_d;
  qdac_pkg::frame_word_t  pend_word_q;
  qdac_pkg::frame_word_t  pend_word_d;
  logic                   fifo_in_ready;
  logic                   pushed;

  logic                   fifo_out_valid;
  logic                   fifo_out_ready;
  qdac_pkg::frame_word_t  fifo_out_data;
  logic                   popped;
  logic                   addr_ok;

  qdac_pkg::code_bank_t   input_q;
  qdac_pkg::code_bank_t   input_d;
  qdac_pkg::code_bank_t   latch_q;
  qdac_pkg::code_bank_t   latch_d;
  qdac_pkg::code_bank_t   analog_out_d;
  logic                   grounded_d;
  logic                   word_accepted_d;
  logic                   word_rejected_d;
  logic                   word_dropped_d;

  // ==========================================================================
  // Link-domain shifter.
  // ==========================================================================
  // Runs on the serial clock and hands out each full word with a toggle.
  // The word holds for a whole frame, far longer than the toggle takes to cross.
  serial_shifter u_shifter (
    .sclk                      (sclk),
    .frame_sync_n              (frame_sync_n),
    .serial_data               (serial_data),
    .package_addr_check_enable (package_addr_check_enable),
    .rst_n                     (rst_n),
    .word_q                    (link_word),
    .word_toggle_q             (link_toggle)
  );

  // ==========================================================================
  // Synchronisers.
  // ==========================================================================
  // Every pin and the link toggle pass two flops before logic reads them, except the clear pin into the grounded flag.
  // The third load and toggle stages exist only to find edges; their reset
  // values match the idle levels so that no false edge follows reset.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tog_s1_q   <= 1'b0;
      tog_s2_q   <= 1'b0;
      tog_s3_q   <= 1'b0;
      strap_s1_q <= 5'h00;
      strap_s2_q <= 5'h00;
      load_s1_q  <= 1'b1;
      load_s2_q  <= 1'b1;
      load_s3_q  <= 1'b1;
      clr_s1_q   <= 1'b0;
      clr_s2_q   <= 1'b0;
      sg_s1_q    <= qdac_pkg::CODE_RESET;
      sg_s2_q    <= qdac_pkg::CODE_RESET;
    end else if (ce) begin
      tog_s1_q   <= link_toggle;
      tog_s2_q   <= tog_s1_q;
      tog_s3_q   <= tog_s2_q;
      strap_s1_q <= package_addr_strap; // RULE2
      strap_s2_q <= strap_s1_q;
      load_s1_q  <= load_converter_n;
      load_s2_q  <= load_s1_q;
      load_s3_q  <= load_s2_q;
      clr_s1_q   <= clear_outputs_n;
      clr_s2_q   <= clr_s1_q;
      sg_s1_q    <= sense_ground_ref;
      sg_s2_q    <= sg_s1_q;
    end
  end

  // Word arrival and load falling edge, both seen on synchronised copies.
  assign word_event = tog_s2_q ^ tog_s3_q;
  assign load_fall  = load_s3_q & ~load_s2_q; // RULE8

  // ==========================================================================
  // Word capture into the buffer.
  // ==========================================================================
  // The held link word is stable long after its toggle is seen, so it is
  // copied here; a word that finds the pending slot still full is dropped.
  // While ce is low the toggle stages are frozen, so two words that arrive
  // in that time cancel out and neither is seen; hosts should not stream
  // into a block whose enable is low.
  always_comb begin
    pushed         = pend_valid_q && fifo_in_ready;
    pend_valid_d   = pend_valid_q && !pushed;
    pend_word_d    = pend_word_q;
    word_dropped_d = 1'b0;
    if (word_event) begin
      if (pend_valid_q && !pushed) begin
        word_dropped_d = 1'b1;
      end else begin
        pend_valid_d = 1'b1;
        pend_word_d  = link_word;
      end
    end
  end

  // Pending slot registers.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pend_valid_q <= 1'b0;
      pend_word_q  <= qdac_pkg::FRAME_RESET;
      word_dropped <= 1'b0;
    end else if (ce) begin
      pend_valid_q <= pend_valid_d;
      pend_word_q  <= pend_word_d;
      word_dropped <= word_dropped_d;
    end
  end

  // Four-word buffer between the link and the input registers.
  word_fifo #(
    .WIDTH (qdac_pkg::FRAME_W),
    .DEPTH (qdac_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .ce        (ce),
    .in_valid  (pend_valid_q),
    .in_ready  (fifo_in_ready),
    .in_data   (pend_word_q),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  // ==========================================================================
  // Address check and input registers.
  // ==========================================================================
  // The drain stalls in the cycle of a load edge so that the copy into the
  // latches sees a settled set of input registers.
  // A refused word still leaves the buffer, so a stream for another package
  // never blocks the words meant for this one.
  always_comb begin
    fifo_out_ready  = !load_fall;
    popped          = fifo_out_valid && fifo_out_ready;
    addr_ok         = fifo_out_data.check_bypass || // RULE4
                      (fifo_out_data.pkg_addr == strap_s2_q); // RULE2 RULE3
    input_d         = input_q;
    word_accepted_d = 1'b0;
    word_rejected_d = 1'b0;
    if (popped) begin
      if (addr_ok) begin
        input_d[fifo_out_data.chan] = fifo_out_data.code; // RULE4 RULE7
        word_accepted_d             = 1'b1;
      end else begin
        word_rejected_d = 1'b1; // RULE3
      end
    end
  end

  // Input register bank and word status pulses.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      input_q       <= '0;
      word_accepted <= 1'b0;
      word_rejected <= 1'b0;
    end else if (ce) begin
      input_q       <= input_d;
      word_accepted <= word_accepted_d;
      word_rejected <= word_rejected_d;
    end
  end

  // ==========================================================================
  // Converter latches.
  // ==========================================================================
  // Load low lets every latch follow its input register; load high holds.
  // The latches take the synchronised level, so a load pulse shorter than
  // one system clock may be missed.
  always_comb begin
    latch_d = latch_q; // RULE7
    if (!load_s2_q) begin
      latch_d = input_q; // RULE6 RULE8
    end
  end

  // Latch bank.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      latch_q <= '0;
    end else if (ce) begin
      latch_q <= latch_d;
    end
  end

  // ==========================================================================
  // Clear handling and outputs.
  // ==========================================================================
  // Grounding is left only by a load edge once clear has gone high again.
  always_comb begin
    grounded_d = outputs_grounded;
    if (load_fall && clr_s2_q) begin
      grounded_d = 1'b0; // RULE11
    end
    if (!clr_s2_q) begin
      grounded_d = 1'b1; // RULE9
    end
  end

  // Only the flag takes the raw pin; the output codes follow the flag
  // through grounded_d and reach sense ground at the next clock edge.
  // The clear pin sets the grounded flag with no clock at all; reset also
  // sets the flag and zeroes the codes, matching a clear held through power-on.
  always_ff @(posedge clk or negedge clear_outputs_n) begin
    if (!clear_outputs_n) begin
      outputs_grounded <= 1'b1; // RULE10
    end else if (!rst_n) begin
      outputs_grounded <= 1'b1; // RULE12
    end else if (ce) begin
      outputs_grounded <= grounded_d;
    end
  end

  // Output codes show sense ground while grounded, otherwise the latches.
  // Next values feed the selection so that codes and flag move together.
  always_comb begin
    for (int i = 0; i < qdac_pkg::NUM_CH; i++) begin
      analog_out_d[i] = grounded_d ? sg_s2_q : latch_d[i]; // RULE9 RULE11
    end
  end

  // Output code registers.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      analog_out <= '0;
    end else if (ce) begin
      analog_out <= analog_out_d;
    end
  end

endmodule

`default_nettype wire

/* rtl/serial_shifter.sv */
`timescale 1ns/1ps
`default_nettype none

module serial_shifter (
  // Link side.
  input  wire logic                 sclk,
  input  wire logic                 frame_sync_n,
  input  wire logic                 serial_data,
  input  wire logic                 package_addr_check_enable,
  // Link-domain reset, asynchronous to the serial clock.
  input  wire logic                 rst_n,
  // Completed word and its event toggle.
  output var qdac_pkg::frame_word_t word_q,
  output logic                      word_toggle_q
);

  logic [qdac_pkg::CNT_BITS-1:0]  cnt_q;
  logic [qdac_pkg::CNT_BITS-1:0]  cnt_d;
  logic [qdac_pkg::WORD_BITS-1:0] shift_q;
  logic [qdac_pkg::WORD_BITS-1:0] shift_d;
  logic [qdac_pkg::WORD_BITS-1:0] full_w;
  qdac_pkg::frame_word_t          word_d;
  logic                           word_toggle_d;

  // ==========================================================================
  // Shift path.
  // ==========================================================================
  // Next bit count and shift contents; a full word saturates the count.
  always_comb begin
    full_w        = {shift_q[qdac_pkg::WORD_BITS-2:0], serial_data};
    shift_d       = full_w; // RULE1
    cnt_d         = cnt_q + 5'h01;
    word_d        = word_q;
    word_toggle_d = word_toggle_q;
    if (cnt_q == qdac_pkg::CNT_DONE) begin
      cnt_d   = cnt_q; // RULE14
      shift_d = shift_q;
    end else if (cnt_q == qdac_pkg::CNT_LAST) begin
      word_d.check_bypass = package_addr_check_enable;
      word_d.pkg_addr     = full_w[qdac_pkg::PA_MSB:qdac_pkg::PA_LSB]; // RULE13
      word_d.chan         = full_w[qdac_pkg::CH_MSB:qdac_pkg::CH_LSB];
      word_d.code         = full_w[qdac_pkg::CODE_MSB:qdac_pkg::CODE_LSB];
      word_toggle_d       = ~word_toggle_q;
    end
  end

  // Frame sync high clears the count at once, so a cut frame is dropped;
  // reset clears it too, since frame sync may idle high from power-on.
  always_ff @(negedge sclk or posedge frame_sync_n or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q   <= qdac_pkg::CNT_ZERO;
      shift_q <= '0;
    end else if (frame_sync_n) begin
      cnt_q   <= qdac_pkg::CNT_ZERO; // RULE5 RULE14
      shift_q <= '0;
    end else begin
      cnt_q   <= cnt_d;
      shift_q <= shift_d;
    end
  end

  // Completed word holds until the next full frame.
  always_ff @(negedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      word_q        <= qdac_pkg::FRAME_RESET;
      word_toggle_q <= 1'b0;
    end else begin
      word_q        <= word_d;
      word_toggle_q <= word_toggle_d;
    end
  end

endmodule

`default_nettype wire

/* rtl/word_fifo.sv */
`timescale 1ns/1ps
`default_nettype none

module word_fifo #(
  parameter int unsigned WIDTH = 22,
  parameter int unsigned DEPTH = 4
) (
  // Clock, reset and enable.
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             ce,
  // Filling side.
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Draining side.
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    wr_d;
  logic [AW-1:0]    rd_q;
  logic [AW-1:0]    rd_d;
  logic [AW:0]      cnt_q;
  logic [AW:0]      cnt_d;
  logic             push;
  logic             pop;

  // Status and pointer updates.
  always_comb begin
    in_ready  = (cnt_q != DEPTH[AW:0]);
    out_valid = (cnt_q != '0);
    out_data  = mem_q[rd_q];
    push      = in_valid && in_ready;
    pop       = out_valid && out_ready;
    wr_d      = push ? AW'(wr_q + 1'b1) : wr_q;
    rd_d      = pop ? AW'(rd_q + 1'b1) : rd_q;
    cnt_d     = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  end

  // Storage and pointers.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else if (ce) begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
      if (push) begin
        mem_q[wr_q] <= in_data;
      end
    end
  end

endmodule

`default_nettype wire

/* tb/host_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// Host side of the serial link.
// ==========================================================================
module host_model (
  // Link lines driven by the host.
  output logic sclk,
  output logic frame_sync_n,
  output logic serial_data
);
  // The link clock stands high between frames.
  initial begin
    sclk = 1'b1;
    frame_sync_n = 1'b1;
    serial_data = 1'b0;
  end

  // Sends the top n bits of w, first bit most significant, 48 ns a bit.
  task automatic send(input logic [27:0] w, input int n);
    frame_sync_n = 1'b0;
    #24;
    for (int i = 0; i < n; i++) begin
      serial_data = w[27-i];
      #24 sclk = 1'b0;
      #24 sclk = 1'b1;
    end
    frame_sync_n = 1'b1;
    serial_data = ~serial_data;
  endtask

  // Clock edges with no frame around them.
  task automatic stray();
    repeat (3) begin
      #24 sclk = 1'b0;
      #24 sclk = 1'b1;
    end
  endtask
endmodule

`default_nettype wire

/* tb/qdac_properties.sv */
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// Port checker for the serial load control.
// ==========================================================================
module qdac_props (
  // Clock and reset.
  input wire logic                 clk,
  input wire logic                 rst_n,
  // Inputs watched.
  input wire logic                 frame_sync_n,
  input wire logic                 load_converter_n,
  input wire logic                 clear_outputs_n,
  input wire logic [13:0]          sense_ground_ref,
  // Outputs watched.
  input wire qdac_pkg::code_bank_t analog_out,
  input wire logic                 outputs_grounded,
  input wire logic                 word_accepted,
  input wire logic                 word_rejected,
  input wire logic                 word_dropped
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // All four channels show the ground code.
  logic gnd_all;
  assign gnd_all = (analog_out == {4{sense_ground_ref}});

  // Assertions on the converter side and the word status pulses.
  a_clear_sets_flag: assert property (!clear_outputs_n |-> outputs_grounded)
    else $error("grounded flag low while clear is low");
  a_clear_ground_code: assert property (!clear_outputs_n [*6] |-> gnd_all)
    else $error("outputs not at sense ground during clear");
  a_ground_holds: assert property (load_converter_n [*4] ##0 outputs_grounded |=> outputs_grounded)
    else $error("grounding released without load");
  a_latch_hold_high: assert property (load_converter_n [*5] ##0 !outputs_grounded |=> $stable(analog_out))
    else $error("outputs moved while load is high");
  a_load_release: assert property (clear_outputs_n [*4] ##0 $fell(load_converter_n) ##1
      (!load_converter_n && clear_outputs_n) [*2] |-> ##[0:2] !outputs_grounded)
    else $error("load did not release grounding");
  a_pulse_onehot: assert property ($onehot0({word_accepted, word_rejected, word_dropped}))
    else $error("more than one word status pulse");
  a_word_in_frame: assert property ((word_accepted || word_rejected) |-> $past(frame_sync_n, 10) == 1'b0)
    else $error("word status without a frame");
  a_reset_state: assert property (disable iff (1'b0)
      !rst_n |=> outputs_grounded && analog_out == '0 && !word_accepted)
    else $error("wrong state in reset");

  // Main scenarios reached.
  c_accepted: cover property (word_accepted);
  c_rejected: cover property (word_rejected);
  c_release: cover property ($fell(outputs_grounded));
endmodule

bind quad_dac_serial_load_control qdac_props u_props (
  .clk(clk), .rst_n(rst_n), .frame_sync_n(frame_sync_n), .load_converter_n(load_converter_n),
  .clear_outputs_n(clear_outputs_n), .sense_ground_ref(sense_ground_ref), .analog_out(analog_out),
  .outputs_grounded(outputs_grounded), .word_accepted(word_accepted), .word_rejected(word_rejected),
  .word_dropped(word_dropped)
);

`default_nettype wire

/* tb/testbench.sv */
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// Bench top.
// ==========================================================================
module testbench;
  logic                 clk = 1'b0;
  logic                 rst_n = 1'b1;
  logic                 ce;
  logic                 package_addr_check_enable;
  logic [4:0]           package_addr_strap;
  logic                 load_converter_n;
  logic                 clear_outputs_n;
  logic [13:0]          sense_ground_ref;
  wire logic            sclk;
  wire logic            frame_sync_n;
  wire logic            serial_data;
  qdac_pkg::code_bank_t analog_out;
  logic                 outputs_grounded;
  logic                 word_accepted;
  logic                 word_rejected;
  logic                 word_dropped;
  qdac_pkg::code_bank_t exp_in = '0;
  qdac_pkg::code_bank_t exp_lat = '0;
  int                   error_cnt = 0;
  int                   n_tests = 0;
  localparam logic [4:0] OWN_PA = 5'h0B;

  // System clock at 40 MHz.
  always #12.5 clk = ~clk;

  // Host and block under test.
  host_model hm (.sclk(sclk), .frame_sync_n(frame_sync_n), .serial_data(serial_data));
  quad_dac_serial_load_control uut (
    .clk(clk), .rst_n(rst_n), .ce(ce), .sclk(sclk), .frame_sync_n(frame_sync_n),
    .serial_data(serial_data), .package_addr_check_enable(package_addr_check_enable),
    .package_addr_strap(package_addr_strap), .load_converter_n(load_converter_n),
    .clear_outputs_n(clear_outputs_n), .sense_ground_ref(sense_ground_ref), .analog_out(analog_out),
    .outputs_grounded(outputs_grounded), .word_accepted(word_accepted),
    .word_rejected(word_rejected), .word_dropped(word_dropped)
  );

  // Compares one value and counts it.
  task automatic chk(input string what, input logic [55:0] seen, input logic [55:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic test_done();
    $display("checks %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Waits k falling edges.
  task automatic settle(input int k);
    repeat (k) @(negedge clk);
  endtask

  // Watches up to 80 cycles for a status pulse: 1 taken, 2 refused, 4 dropped.
  task automatic wait_word(output logic [2:0] r);
    r = 3'h0;
    for (int i = 0; i < 80 && r == 3'h0; i++) begin
      @(negedge clk);
      r = {word_dropped, word_rejected, word_accepted};
    end
  endtask

  // Sends one frame of n bits and checks the status that follows.
  task automatic wr(input logic [4:0] pa, input logic [1:0] ch, input qdac_pkg::code_t c,
                    input int n, input logic [1:0] e);
    logic [2:0] r;
    fork
      hm.send({pa, ch, 3'h0, c, 4'h0}, n);
      wait_word(r);
    join
    chk("word status", 56'(r), 56'({1'b0, e}));
    if (e == 2'h1) begin
      exp_in[ch] = c;
    end
  endtask

  // Clear held since power-on, then released by the first load.
  task automatic t_power_on();
    settle(6);
    chk("grounded flag", 56'(outputs_grounded), 56'(1));
    chk("output codes", analog_out, {4{sense_ground_ref}});
    clear_outputs_n = 1'b1;
    settle(6);
    chk("grounded flag", 56'(outputs_grounded), 56'(1));
    load_converter_n = 1'b0;
    settle(5);
    chk("grounded flag", 56'(outputs_grounded), 56'(0));
    chk("output codes", analog_out, exp_lat);
    load_converter_n = 1'b1;
    settle(4);
  endtask

  // Writes under load high move no output; one load copies all channels.
  task automatic t_hold();
    wr(OWN_PA, 2'h1, 14'h1234, 24, 2'h1);
    wr(5'h14, 2'h2, 14'h2222, 24, 2'h2);
    package_addr_check_enable = 1'b1;
    wr(5'h14, 2'h2, 14'h3ABC, 24, 2'h1);
    package_addr_check_enable = 1'b0;
    settle(4);
    chk("output codes", analog_out, exp_lat);
    load_converter_n = 1'b0;
    settle(5);
    exp_lat = exp_in;
    chk("output codes", analog_out, exp_lat);
    load_converter_n = 1'b1;
  endtask

  // Cut frames and stray clocks leave nothing; bits past the word are ignored.
  task automatic t_abort();
    logic [2:0] r;
    wr(OWN_PA, 2'h0, 14'h0F0F, 12, 2'h0);
    fork
      hm.stray();
      wait_word(r);
    join
    chk("stray clock status", 56'(r), 56'(0));
    wr(OWN_PA, 2'h0, 14'h0F0F, 26, 2'h1);
    load_converter_n = 1'b0;
    settle(5);
    exp_lat = exp_in;
    chk("output codes", analog_out, exp_lat);
  endtask

  // Load held low follows writes; clear wins and waits for the next load.
  task automatic t_live();
    wr(OWN_PA, 2'h3, 14'h2DB6, 24, 2'h1);
    settle(4);
    exp_lat = exp_in;
    chk("output codes", analog_out, exp_lat);
    clear_outputs_n = 1'b0;
    #2;
    chk("grounded flag", 56'(outputs_grounded), 56'(1));
    settle(5);
    chk("output codes", analog_out, {4{sense_ground_ref}});
    clear_outputs_n = 1'b1;
    settle(6);
    chk("grounded flag", 56'(outputs_grounded), 56'(1));
    load_converter_n = 1'b1;
    settle(4);
    load_converter_n = 1'b0;
    settle(5);
    chk("output codes", analog_out, exp_lat);
  endtask

  // Main sequence; clear is held low through power-on.
  initial begin
    ce = 1'b1;
    package_addr_check_enable = 1'b0;
    package_addr_strap = OWN_PA;
    load_converter_n = 1'b1;
    clear_outputs_n = 1'b0;
    sense_ground_ref = 14'h0A5A;
    #1 rst_n = 1'b0; // Falls after time zero so the link side sees the edge.
    settle(3);
    rst_n = 1'b1;
    t_power_on();
    t_hold();
    t_abort();
    t_live();
    test_done();
  end

  // Cuts a hang short well after the expected 12 us of traffic.
  initial begin
    #100000;
    error_cnt++;
    test_done();
  end
endmodule

`default_nettype wire
